// File: logic/fwsr_bus_cycle.sv
`timescale 1ns/1ps
module fwsr_bus_cycle
  import fwsr_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Cycle request.
  input  wire logic              start,
  input  wire logic              is_wr,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DQ_W-1:0]   wdata,
  output logic                   done,
  output logic [DQ_W-1:0]        rdata,
  // Flash pins.
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DQ_W-1:0]        flash_dq_out,
  output logic                   flash_dq_oe,
  input  wire logic [DQ_W-1:0]   flash_dq_in,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n
);
  fwsr_cyc_t          st_reg, st_next;
  logic [3:0]         cnt_reg, cnt_next;
  logic               wr_reg, wr_next;
  logic [ADDR_W-1:0]  addr_reg, addr_next;
  logic [DQ_W-1:0]    wd_reg, wd_next, rd_reg, rd_next;
  logic               ce_n_reg, ce_n_next, oe_n_reg, oe_n_next;
  logic               we_n_reg, we_n_next, dq_oe_reg, dq_oe_next;

  // Every strobe closes on a gap cycle so that successive status reads are
  // separate read cycles, which the toggle bits need to advance.
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    wr_next   = wr_reg;
    addr_next = addr_reg;
    wd_next   = wd_reg;
    rd_next   = rd_reg;
    unique case (st_reg)
      CY_IDLE: if (start) begin
        st_next   = CY_SETUP;
        wr_next   = is_wr;
        addr_next = addr;
        wd_next   = wdata;
      end
      CY_SETUP: begin
        st_next  = CY_STROBE;
        cnt_next = (wr_reg ? WP_CYC : ACC_CYC) - 4'h1;
      end
      CY_STROBE: if (cnt_reg == 4'h0) begin
        st_next = CY_GAP;
        if (!wr_reg) begin
          rd_next = flash_dq_in;
        end
      end else begin
        cnt_next = cnt_reg - 4'h1;
      end
      CY_GAP: st_next = CY_IDLE;
    endcase
    ce_n_next  = !(st_next == CY_SETUP || st_next == CY_STROBE);
    oe_n_next  = !(st_next == CY_STROBE && !wr_next);
    we_n_next  = !(st_next == CY_STROBE && wr_next);
    dq_oe_next = wr_next && (st_next != CY_IDLE);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg    <= CY_IDLE;
      cnt_reg   <= 4'h0;
      wr_reg    <= 1'b0;
      addr_reg  <= ADDR_RST;
      wd_reg    <= WDATA_RST;
      rd_reg    <= WDATA_RST;
      ce_n_reg  <= 1'b1;
      oe_n_reg  <= 1'b1;
      we_n_reg  <= 1'b1;
      dq_oe_reg <= 1'b0;
    end else begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      wr_reg    <= wr_next;
      addr_reg  <= addr_next;
      wd_reg    <= wd_next;
      rd_reg    <= rd_next;
      ce_n_reg  <= ce_n_next;
      oe_n_reg  <= oe_n_next;
      we_n_reg  <= we_n_next;
      dq_oe_reg <= dq_oe_next;
    end
  end

  assign done         = (st_reg == CY_GAP);
  assign rdata        = rd_reg;
  assign flash_addr   = addr_reg;
  assign flash_dq_out = wd_reg;
  assign flash_dq_oe  = dq_oe_reg;
  assign flash_ce_n   = ce_n_reg;
  assign flash_oe_n   = oe_n_reg;
  assign flash_we_n   = we_n_reg;

  sequence s_we_pulse;
    !flash_we_n [*2] ##1 flash_we_n;
  endsequence
  sequence s_oe_pulse;
    !flash_oe_n [*3] ##1 flash_oe_n;
  endsequence

  chk_strobe_excl: assert property (@(posedge clk_sys) disable iff (rst)
    !(!flash_oe_n && !flash_we_n)) else $error("oe and we low together");
  chk_dq_contention: assert property (@(posedge clk_sys) disable iff (rst)
    flash_dq_oe |-> flash_oe_n) else $error("dq driven while flash outputs");
  chk_we_width: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(flash_we_n) |-> s_we_pulse) else $error("write strobe width wrong");
  chk_read_width: assert property (@(posedge clk_sys) disable iff (rst) // R17
    $fell(flash_oe_n) |-> s_oe_pulse ##0 done) else $error("read strobe width wrong");
  chk_cycle_done: assert property (@(posedge clk_sys) disable iff (rst)
    (st_reg == CY_IDLE && start) |-> ##[4:5] done) else $error("cycle did not finish");
endmodule : fwsr_bus_cycle

// File: logic/fwsr_ctrl.sv
`timescale 1ns/1ps
// How it works
// R1: Device pulls ready line low while busy.
// R2: Ready line valid after last write strobe.
// R3: Toggle bit flips on each status read.
// R4: Toggle bit valid through erase window.
// R5: All-protected erase toggles about 100 us.
// R6: Protected program toggles about 2 us.
// R7: Erase skips protected sectors silently.
// R8: Toggle stops in suspend, resumes for program.
// R9: Sector toggle flips inside erasing sectors.
// R10: Timeout bit high on pulse limit overrun.
// R11: Programming a zero to one times out; the flash model ANDs the word into memory and raises no timeout.
// R12: Host writes reset after timeout failure.
// R13: Window bit rises when erase window expires.
// R14: Closed window ignores all but suspend.
// R15: Skip window check only under 50 us spacing.
// R16: Check window bit before and after erase.
// R17: Two reads compared decide toggling.
// R18: Recheck toggle when timeout bit high.
// R19: Resumed polling restarts from double read.
// R20: Polling bit shows complement until done.
// R21: Suspended non-erasing reads return data.
module fwsr_ctrl
  import fwsr_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // AXI4-Lite write channels.
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Flash pins.
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DQ_W-1:0]        flash_dq_out,
  output logic                   flash_dq_oe,
  input  wire logic [DQ_W-1:0]   flash_dq_in,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  input  wire logic              ready_busy_n
);
  function automatic logic fwsr_mapped(input logic [AXI_AW-1:0] a);
    fwsr_mapped = (a == REG_CTRL) || (a == REG_ADDR) || (a == REG_WDATA) ||
                  (a == REG_STATUS) || (a == REG_RDATA);
  endfunction : fwsr_mapped

  function automatic logic [31:0] fwsr_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    fwsr_merge = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        fwsr_merge[8*i +: 8] = new_v[8*i +: 8];
      end
    end
  endfunction : fwsr_merge

  // Register bus state.
  logic              aw_got_reg, aw_got_next, w_got_reg, w_got_next;
  logic [AXI_AW-1:0] awa_reg, awa_next;
  logic [31:0]       wd_reg, wd_next;
  logic [3:0]        ws_reg, ws_next;
  logic              bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic [31:0]       addr_reg, addr_next, wdat_reg, wdat_next;
  logic              wr_fire, ctrl_wr;
  logic [31:0]       status_word;

  // Sequencer state.
  fwsr_seq_t         state_reg, state_next;
  logic              issued_reg, issued_next, abort_reg, abort_next;
  logic              one_wr_reg, one_wr_next, tog_reg, tog_next;
  logic              done_reg, done_next, fail_reg, fail_next;
  logic              refused_reg, refused_next, maybe_reg, maybe_next;
  logic [DQ_W-1:0]   last_reg, last_next;
  logic              rb_reg;
  logic              cyc_start, cyc_wr, cyc_done;
  logic [DQ_W-1:0]   cyc_wdata, cyc_rdata;

  assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
  assign ctrl_wr = wr_fire && (awa_reg == REG_CTRL) && ws_reg[0];
  assign status_word = {25'h0000000, tog_reg, rb_reg, maybe_reg, refused_reg,
                        fail_reg, done_reg, !state_reg[0]};

  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    awa_next    = awa_reg;
    wd_next     = wd_reg;
    ws_next     = ws_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    addr_next   = addr_reg;
    wdat_next   = wdat_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_next = 1'b1;
      awa_next    = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_next = 1'b1;
      wd_next    = s_axi_wdata;
      ws_next    = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = fwsr_mapped(awa_reg) ? 2'h0 : 2'h2;
      if (awa_reg == REG_ADDR) begin
        addr_next = fwsr_merge(addr_reg, wd_reg, ws_reg) & 32'h000fffff;
      end
      if (awa_reg == REG_WDATA) begin
        wdat_next = fwsr_merge(wdat_reg, wd_reg, ws_reg) & 32'h0000ffff;
      end
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = fwsr_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      unique case (s_axi_araddr)
        REG_ADDR:   rdata_next = addr_reg;
        REG_WDATA:  rdata_next = wdat_reg;
        REG_STATUS: rdata_next = status_word;
        REG_RDATA:  rdata_next = {16'h0000, last_reg};
        default:    rdata_next = 32'h00000000;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awa_reg    <= 8'h00;
      wd_reg     <= 32'h00000000;
      ws_reg     <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= 2'h0;
      rvalid_reg <= 1'b0;
      rresp_reg  <= 2'h0;
      rdata_reg  <= 32'h00000000;
      addr_reg   <= 32'h00000000;
      wdat_reg   <= 32'h00000000;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      awa_reg    <= awa_next;
      wd_reg     <= wd_next;
      ws_reg     <= ws_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
      addr_reg   <= addr_next;
      wdat_reg   <= wdat_next;
    end
  end

  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready  = !w_got_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // Commands written while busy are dropped; only abort is heard then, and it
  // ends a poll only when a second status read that still toggles without timeout completes, never in mid strobe.
  always_comb begin
    state_next   = state_reg;
    issued_next  = issued_reg;
    abort_next   = abort_reg || (ctrl_wr && wd_reg[CTRL_ABORT] && !state_reg[0]);
    one_wr_next  = one_wr_reg;
    tog_next     = tog_reg;
    done_next    = done_reg;
    fail_next    = fail_reg;
    refused_next = refused_reg;
    maybe_next   = maybe_reg;
    last_next    = last_reg;
    cyc_start    = 1'b0;
    cyc_wr       = (state_reg == S_RST) || (state_reg == S_WCMD) ||
                   ((state_reg == S_ONE) && one_wr_reg);
    cyc_wdata    = (state_reg == S_RST) ? CMD_RESET :
                   (state_reg == S_WCMD) ? CMD_SECTOR_ERASE : wdat_reg[DQ_W-1:0];
    if (state_reg == S_IDLE) begin
      if (ctrl_wr && !wd_reg[CTRL_ABORT]) begin
        abort_next   = 1'b0;
        done_next    = 1'b0;
        fail_next    = 1'b0;
        refused_next = 1'b0;
        maybe_next   = 1'b0;
        unique case (wd_reg[CTRL_OP_LSB +: 3])
          OP_WRITE:     begin state_next = S_ONE; one_wr_next = 1'b1; end
          OP_READ:      begin state_next = S_ONE; one_wr_next = 1'b0; end
          OP_POLL:      state_next = S_RD1;
          OP_ERASE_ADD: state_next = S_WPRE; // R15 R16
          OP_RESET:     state_next = S_RST;
          default:      done_next = 1'b1;
        endcase
      end
    end else if (!issued_reg) begin
      cyc_start   = 1'b1;
      issued_next = 1'b1;
    end else if (cyc_done) begin
      issued_next = 1'b0;
      if (!cyc_wr) begin
        last_next = cyc_rdata;
      end
      unique case (state_reg)
        S_RD1, S_RD3: begin
          tog_next   = cyc_rdata[DQ_TOGGLE_BIT]; // R3
          state_next = (state_reg == S_RD1) ? S_RD2 : S_RD4;
        end
        S_RD2: begin
          if (cyc_rdata[DQ_TOGGLE_BIT] == tog_reg) begin
            state_next = S_IDLE; // R17
            done_next  = 1'b1;
          end else if (cyc_rdata[DQ_TIMEOUT_BIT]) begin
            state_next = S_RD3; // R10 R18
          end else if (abort_reg) begin
            state_next = S_IDLE;
            done_next  = 1'b1;
          end else begin
            state_next = S_RD1; // R19
          end
        end
        S_RD4: begin
          if (cyc_rdata[DQ_TOGGLE_BIT] == tog_reg) begin
            state_next = S_IDLE;
            done_next  = 1'b1;
          end else begin
            state_next = S_RST; // R12 R18
            fail_next  = 1'b1;
          end
        end
        S_RST, S_WPOST, S_ONE: begin
          state_next = S_IDLE;
          done_next  = 1'b1;
          if (state_reg == S_WPOST) begin
            maybe_next = cyc_rdata[DQ_WINDOW_BIT]; // R13 R16
          end
        end
        S_WPRE: begin
          if (cyc_rdata[DQ_WINDOW_BIT]) begin
            state_next   = S_IDLE; // R14 R16
            refused_next = 1'b1;
            done_next    = 1'b1;
          end else begin
            state_next = S_WCMD;
          end
        end
        S_WCMD: state_next = S_WPOST;
        default: state_next = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg   <= S_IDLE;
      issued_reg  <= 1'b0;
      abort_reg   <= 1'b0;
      one_wr_reg  <= 1'b0;
      tog_reg     <= 1'b0;
      done_reg    <= 1'b0;
      fail_reg    <= 1'b0;
      refused_reg <= 1'b0;
      maybe_reg   <= 1'b0;
      last_reg    <= WDATA_RST;
      rb_reg      <= 1'b1;
    end else begin
      state_reg   <= state_next;
      issued_reg  <= issued_next;
      abort_reg   <= abort_next;
      one_wr_reg  <= one_wr_next;
      tog_reg     <= tog_next;
      done_reg    <= done_next;
      fail_reg    <= fail_next;
      refused_reg <= refused_next;
      maybe_reg   <= maybe_next;
      last_reg    <= last_next;
      rb_reg      <= ready_busy_n; // R1 R2
    end
  end

  fwsr_bus_cycle u_cycle (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .start        (cyc_start),
    .is_wr        (cyc_wr),
    .addr         (addr_reg[ADDR_W-1:0]),
    .wdata        (cyc_wdata),
    .done         (cyc_done),
    .rdata        (cyc_rdata),
    .flash_addr   (flash_addr),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_dq_in  (flash_dq_in),
    .flash_ce_n   (flash_ce_n),
    .flash_oe_n   (flash_oe_n),
    .flash_we_n   (flash_we_n)
  );

  chk_fail_reset: assert property (@(posedge clk_sys) disable iff (rst) // R12
    $rose(fail_reg) |-> state_reg == S_RST ##[1:8] (!flash_we_n && flash_dq_out == CMD_RESET))
    else $error("failure not followed by reset command");
  chk_refused_quiet: assert property (@(posedge clk_sys) disable iff (rst) // R14
    $rose(refused_reg) |-> flash_we_n [*8]) else $error("write after closed window");
  chk_ok_equal: assert property (@(posedge clk_sys) disable iff (rst) // R17
    (state_reg == S_RD2 && cyc_done && cyc_rdata[DQ_TOGGLE_BIT] == tog_reg) |=>
    state_reg == S_IDLE) else $error("equal toggle reads did not end poll");
  chk_restart_poll: assert property (@(posedge clk_sys) disable iff (rst) // R19
    (state_reg == S_RD2 && cyc_done && cyc_rdata[DQ_TOGGLE_BIT] != tog_reg &&
     !cyc_rdata[DQ_TIMEOUT_BIT] && !abort_reg) |=> state_reg == S_RD1)
    else $error("poll did not restart from first read");
  chk_b_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (@(posedge clk_sys) disable iff (rst)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
endmodule : fwsr_ctrl

// File: logic/fwsr_pkg.sv
package fwsr_pkg;
  // Flash and register bus geometry.
  localparam int ADDR_W = 20;
  localparam int DQ_W   = 16;
  localparam int AXI_AW = 8;

  // Own register map, byte addresses of aligned words.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;

  // Control register fields and operation codes.
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_ABORT  = 3;
  localparam logic [2:0] OP_WRITE     = 3'h1;
  localparam logic [2:0] OP_READ      = 3'h2;
  localparam logic [2:0] OP_POLL      = 3'h3;
  localparam logic [2:0] OP_ERASE_ADD = 3'h4;
  localparam logic [2:0] OP_RESET     = 3'h5;

  // Status register fields.
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_FAIL    = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_MAYBE   = 4;
  localparam int ST_READY   = 5;
  localparam int ST_TOGGLE  = 6;

  // Status positions on the flash data bus.
  localparam int DQ_POLL_BIT    = 7;
  localparam int DQ_TOGGLE_BIT  = 6;
  localparam int DQ_TIMEOUT_BIT = 5;
  localparam int DQ_WINDOW_BIT  = 3;
  localparam int DQ_SECTOR_BIT  = 2;

  // Flash command data.
  localparam logic [15:0] CMD_RESET        = 16'h00f0;
  localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;

  // Reset values.
  localparam logic [19:0] ADDR_RST  = 20'h00000;
  localparam logic [15:0] WDATA_RST = 16'h0000;

  // Bus cycle timing.
  localparam int CLK_NS   = 40;
  localparam int T_ACC_NS = 120;
  localparam int T_WP_NS  = 50;
  localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WP_CYC  = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [3:0] {
    CY_IDLE   = 4'b0001,
    CY_SETUP  = 4'b0010,
    CY_STROBE = 4'b0100,
    CY_GAP    = 4'b1000
  } fwsr_cyc_t;

  typedef enum logic [9:0] {
    S_IDLE  = 10'b0000000001,
    S_RD1   = 10'b0000000010,
    S_RD2   = 10'b0000000100,
    S_RD3   = 10'b0000001000,
    S_RD4   = 10'b0000010000,
    S_RST   = 10'b0000100000,
    S_WPRE  = 10'b0001000000,
    S_WCMD  = 10'b0010000000,
    S_WPOST = 10'b0100000000,
    S_ONE   = 10'b1000000000
  } fwsr_seq_t;
endpackage : fwsr_pkg

// File: tb/fwsr_flash_model.sv
`timescale 1ns/1ps
module fwsr_flash_model
  import fwsr_pkg::*;
(
  // Bus pins.
  input  wire logic [ADDR_W-1:0] flash_addr,
  input  wire logic [DQ_W-1:0]   flash_dq_out,
  output logic [DQ_W-1:0]        flash_dq_in,
  input  wire logic              flash_ce_n,
  input  wire logic              flash_oe_n,
  input  wire logic              flash_we_n,
  input  wire logic              flash_dq_oe,
  output logic                   busy_pull_low,
  // Scenario settings.
  input  wire logic [3:0]        busy_reads,
  input  wire logic              fail_mode,
  input  wire logic [3:0]        win_reads
);
  logic [DQ_W-1:0] mem [16];
  logic [DQ_W-1:0] last_q;
  logic [DQ_W-1:0] prog_q;
  logic [3:0]      busy_cnt;
  logic [3:0]      win_cnt;
  logic            busy;
  logic            failing;
  logic            erasing;
  logic            tog;
  logic            rd_act;
  logic            wr_act;
  logic [3:0]      er_a;
  logic [3:0]      a;

  assign rd_act = (flash_ce_n === 1'b0) && (flash_oe_n === 1'b0) && (flash_we_n === 1'b1);
  assign wr_act = (flash_ce_n === 1'b0) && (flash_we_n === 1'b0);
  assign a = flash_addr[3:0];
  assign busy_pull_low = busy;

  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
    {busy, failing, erasing, tog} = 4'h0;
    {busy_cnt, win_cnt} = 8'h00;
    {last_q, prog_q} = 32'h0;
  end

  // A write ends when either strobe rises, so the data must still be driven then.
  // Locations 12 to 15 stand for a protected sector.
  always @(negedge wr_act) begin
    if (flash_dq_oe === 1'b1) begin
      if (flash_dq_out == CMD_RESET) begin
        {busy, failing, erasing} = 3'h0;
      end else if (flash_dq_out == CMD_SECTOR_ERASE) begin
        if (!(erasing && win_cnt == 4'h0)) begin
          erasing = 1'b1;
          win_cnt = win_reads;
          er_a = a;
          if (a[3:2] != 2'b11) mem[a] = 16'hffff;
        end
      end else if (!busy) begin
        prog_q = mem[a] & flash_dq_out;
        if (a[3:2] != 2'b11) mem[a] = prog_q;
        busy_cnt = busy_reads;
        failing = fail_mode;
        busy = (busy_reads != 4'h0) || fail_mode;
      end
    end
  end

  // A read ends when either strobe rises.
  always @(negedge rd_act) begin
    if (busy || erasing) tog = !tog;
    if (busy) begin
      if (!failing) begin
        busy_cnt = busy_cnt - 4'h1;
        if (busy_cnt == 4'h0) busy = 1'b0;
      end
    end
    if (erasing && win_cnt != 4'h0) win_cnt = win_cnt - 4'h1;
  end

  // A released bus shows the inverse of the last word so stale data never passes.
  always @(flash_dq_in) if (rd_act) last_q = flash_dq_in;

  always @* begin
    if (!rd_act) begin
      flash_dq_in = ~last_q;
    end else begin
      flash_dq_in = mem[a];
      if (busy) begin
        flash_dq_in[DQ_POLL_BIT] = ~prog_q[DQ_POLL_BIT];
        flash_dq_in[DQ_TOGGLE_BIT] = tog;
        flash_dq_in[DQ_TIMEOUT_BIT] = failing;
      end
      if (erasing) flash_dq_in[DQ_WINDOW_BIT] = (win_cnt == 4'h0);
      if (erasing && a == er_a) flash_dq_in[DQ_SECTOR_BIT] = tog;
    end
  end
endmodule : fwsr_flash_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import fwsr_pkg::*;
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic [7:0]        s_axi_awaddr = 8'h00;
  logic [7:0]        s_axi_araddr = 8'h00;
  logic [31:0]       s_axi_wdata = 32'h0;
  logic [3:0]        s_axi_wstrb = 4'hf;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
  logic [31:0]       s_axi_rdata, st, rd;
  logic [ADDR_W-1:0] flash_addr;
  logic [DQ_W-1:0]   flash_dq_out, flash_dq_in;
  logic              flash_ce_n, flash_oe_n, flash_we_n, pull_low, flash_dq_oe;
  logic [3:0]        busy_reads = 4'h0, win_reads = 4'h0;
  logic              fail_mode = 1'b0;
  int                err_total = 0, checked = 0, cycles = 0;
  wire               ready_busy_n = pull_low ? 1'b0 : 1'b1;

  always #20 clk_sys = ~clk_sys;

  fwsr_ctrl fwsr_ctrl_inst (.clk_sys(clk_sys), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .ready_busy_n(ready_busy_n));

  fwsr_flash_model fwsr_flash_model_inst (.flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n), .busy_pull_low(pull_low), .busy_reads(busy_reads),
    .fail_mode(fail_mode), .win_reads(win_reads), .flash_dq_oe(flash_dq_oe));

  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  // A hung handshake would stall the run, so a cycle ceiling ends it.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic a_ok;
    logic w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge clk_sys);
      if (!a_ok && s_axi_awready) begin a_ok = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!w_ok && s_axi_wready) begin w_ok = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic op(input logic [2:0] c);
    axi_wr(REG_CTRL, {29'h0, c}, resp);
    st = 32'h0;
    while (st[ST_DONE] !== 1'b1) axi_rd(REG_STATUS, st, resp);
  endtask : op

  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    axi_rd(REG_STATUS, st, resp);
    chk({st[ST_BUSY], st[ST_READY]}, 32'h1);
    axi_rd(8'h20, rd, resp);
    chk(resp, 32'h2);
    axi_wr(8'h20, 32'h0, resp);
    chk(resp, 32'h2);
    axi_wr(REG_ADDR, 32'h3, resp);
    s_axi_wstrb <= 4'h2;
    axi_wr(REG_ADDR, 32'h7700, resp);
    s_axi_wstrb <= 4'hf;
    axi_rd(REG_ADDR, rd, resp);
    chk(rd, 32'h7703);
    axi_wr(REG_WDATA, 32'ha5, resp);
    op(OP_WRITE);
    axi_wr(REG_WDATA, 32'hff, resp);
    op(OP_WRITE);
    op(OP_READ);
    axi_rd(REG_RDATA, rd, resp);
    chk(rd, 32'ha5);
    busy_reads <= 4'h4;
    axi_wr(REG_ADDR, 32'h5, resp);
    axi_wr(REG_WDATA, 32'h81, resp);
    op(OP_WRITE);
    chk(st[ST_READY], 32'h0);
    op(OP_READ);
    axi_rd(REG_RDATA, rd, resp);
    chk(rd[DQ_POLL_BIT], 32'h0);
    op(OP_POLL);
    chk({st[ST_FAIL], st[ST_READY]}, 32'h1);
    axi_wr(REG_ADDR, 32'hf, resp);
    op(OP_WRITE);
    op(OP_POLL);
    op(OP_READ);
    axi_rd(REG_RDATA, rd, resp);
    chk(rd, 32'hffff);
    fail_mode <= 1'b1;
    axi_wr(REG_ADDR, 32'h6, resp);
    op(OP_WRITE);
    op(OP_POLL);
    chk({st[ST_FAIL], st[ST_READY]}, 32'h3);
    chk(ready_busy_n, 32'h1);
    fail_mode <= 1'b0;
    win_reads <= 4'h8;
    axi_wr(REG_ADDR, 32'h3, resp);
    op(OP_ERASE_ADD);
    chk({st[ST_REFUSED], st[ST_MAYBE]}, 32'h0);
    win_reads <= 4'h0;
    op(OP_ERASE_ADD);
    chk({st[ST_REFUSED], st[ST_MAYBE]}, 32'h1);
    op(OP_ERASE_ADD);
    chk({st[ST_REFUSED], st[ST_MAYBE]}, 32'h2);
    op(OP_RESET);
    chk(st[ST_BUSY], 32'h0);
    op(OP_READ);
    axi_rd(REG_RDATA, rd, resp);
    chk(rd, 32'hffff);
    report_and_stop();
  end
endmodule : tb_top
